/* dv/scg_sleep_gate_asserts.sv */
`timescale 1ns/1ps
`include "scg_defines.svh"
module scg_sleep_gate_asserts
(
  input wire logic                clock,
  input wire logic                rstn,
  input wire logic                pwrite,
  input wire scg_pkg::scg_addr_t  paddr,
  input wire scg_pkg::scg_word_t  pwdata,
  input wire logic                pready,
  input wire scg_pkg::scg_word_t  prdata,
  input wire scg_pkg::scg_units_t runEnable,
  input wire scg_pkg::scg_units_t unitAccess,
  input wire scg_pkg::scg_units_t unitClkEn,
  input wire logic                unitBusFault,
  input wire logic                sleepActive
);
  // ****
  // gate checks
  // ****
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // read of the gate word, used as the reference
  wire rdG = pready && !pwrite && paddr == `SCG_OFF_SLEEP_GATE;
  port_map_a: assert property (sleepActive && rdG |-> unitClkEn[7:0] == prdata[7:0])
    else $error("port map");
  unit_map_a: assert property (sleepActive && rdG |-> unitClkEn[9:8] == {prdata[16], prdata[13]})
    else $error("unit map");
  rsv_zero_a: assert property (rdG |-> (prdata & ~32'h0001_20FF) == 0)
    else $error("reserved set");
  bus_fault_a: assert property (unitBusFault == |(unitAccess & ~unitClkEn))
    else $error("fault");
  rst_clear_a: assert property ($rose(rstn) |-> !sleepActive && unitClkEn == runEnable)
    else $error("reset");
  auto_need_a: assert property (pready && pwrite && paddr == `SCG_OFF_MODE_CTRL
    |=> sleepActive == (($past(pwdata) & 32'h3) == 32'h3)) else $error("auto");
  sleep_hold_a: assert property (sleepActive && $past(sleepActive) && !pready |-> $stable(unitClkEn))
    else $error("sleep hold");
  run_pass_a: assert property (!sleepActive |-> unitClkEn == runEnable)
    else $error("run pass");
endmodule // scg_sleep_gate_asserts
bind scg_sleep_gate scg_sleep_gate_asserts u_scg_sleep_gate_asserts (.*);

/* dv/scg_unit_model.sv */
`timescale 1ns/1ps
// far-side units: an access line rises only when the bench asks
module scg_unit_model
(
  input  wire logic                clock,
  input  wire scg_pkg::scg_units_t want,
  output scg_pkg::scg_units_t      unitAccess
);
  // launched after an edge so the fault decode sees a clean level
  always_ff @(posedge clock)
    unitAccess <= want;
endmodule // scg_unit_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
`include "scg_defines.svh"
module tb_top;
  import scg_pkg::*;
  logic       clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, clkEn = 1;
  logic       pready, pslverr, unitBusFault, sleepActive;
  scg_addr_t  paddr = '0;
  scg_word_t  pwdata = '0, prdata;
  scg_units_t runEnable = '0, want = '0, unitAccess, unitClkEn;
  int         n_fail = 0, n_compared = 0;
  // clock enable driven by the bench so a stall can be checked
  scg_sleep_gate u_scg_sleep_gate (.*);
  scg_unit_model u_scg_unit_model (.*);
  always #4 clock = ~clock;
  task automatic chk(input scg_word_t s, x);
    n_compared++;
    if (s !== x)
    begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, s, x);
    end
  endtask
  // one transfer; pready sampled at the rising edge, release at that edge
  task automatic apb(input logic w, scg_addr_t a, scg_word_t d, x, logic e);
    @(posedge clock) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clock) penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    if (!w) chk(prdata, x);
    chk(32'(pslverr), 32'(e));
    {psel, penable} <= 0;
  endtask
  // frozen clock enable must hold the transfer off
  task automatic t_stall;
    clkEn <= 0;
    fork
      apb(1, `SCG_OFF_SLEEP_GATE, 32'h80, 0, 0);
      begin
        repeat (4)
        begin
          @(posedge clock);
          chk(32'(pready), 32'(0));
        end
        clkEn <= 1;
      end
    join
    apb(0, `SCG_OFF_SLEEP_GATE, 0, 32'h80, 0);
  endtask
  // reset in mid-run clears the gate word again
  task automatic t_reset;
    @(posedge clock) rstn <= 0;
    repeat (2) @(posedge clock);
    rstn <= 1;
    apb(0, `SCG_OFF_SLEEP_GATE, 0, 0, 0);
  endtask
  task automatic look(input scg_units_t c, logic f);
    repeat (2) @(negedge clock);
    chk(32'(unitClkEn), 32'(c));
    chk(32'(unitBusFault), 32'(f));
  endtask
  task automatic t_regs;
    apb(0, `SCG_OFF_SLEEP_GATE, 0, 0, 0);
    apb(0, `SCG_OFF_MODE_CTRL, 0, 0, 0);
    apb(1, `SCG_OFF_SLEEP_GATE, '1, 0, 0);
    apb(1, 12'h300, 0, 0, 1);
    apb(0, `SCG_OFF_SLEEP_GATE, 0, 32'h0001_20FF, 0);
  endtask
  task automatic t_sleep;
    runEnable <= 10'h155;
    apb(1, `SCG_OFF_SLEEP_GATE, 32'h2001, 0, 0);
    apb(1, `SCG_OFF_MODE_CTRL, 1, 0, 0);
    look(10'h155, 0);
    apb(1, `SCG_OFF_MODE_CTRL, 3, 0, 0);
    runEnable <= 10'h2AA;
    look(10'h101, 0);
    apb(0, `SCG_OFF_SLEEP_GATE, 0, 32'h2001, 0);
    want <= 10'h002;
    look(10'h101, 1);
    want <= 10'h001;
    look(10'h101, 0);
    apb(1, `SCG_OFF_MODE_CTRL, 0, 0, 0);
    look(10'h2AA, 1);
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clock);
    rstn <= 1;
    t_regs;
    t_stall;
    t_sleep;
    t_reset;
    test_done;
  end
  // whole run is under two hundred cycles
  initial
  begin
    #20000;
    n_fail++;
    test_done;
  end
endmodule // tb_top

/* logic/scg_defines.svh */
`ifndef SCG_DEFINES_SVH
`define SCG_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define SCG_ADDR_W        12
`define SCG_OFF_SLEEP_GATE 12'h118
`define SCG_OFF_MODE_CTRL  12'h200
`define SCG_GATE_RESET     32'h0000_0000
`define SCG_GATE_MASK      32'h0001_20FF
`define SCG_MODE_MASK      32'h0000_0003
`define SCG_ZERO_WORD      32'h0000_0000

// ****************************************
// field positions
// ****************************************
`define SCG_BIT_USB       16
`define SCG_BIT_MICRO_DMA_GATE      13
`define SCG_BIT_PORT_LO   0
`define SCG_NUM_PORTS     8
`define SCG_NUM_UNITS     10
`define SCG_BIT_SLEEP     0
`define SCG_BIT_ACG       1
`define SCG_UNIT_USB      9
`define SCG_UNIT_MICRO_DMA_GATE     8

`endif

/* logic/scg_gate_decode.sv */
`timescale 1ns/1ps
`include "scg_defines.svh"

// unit enable and bus-fault decode; combinational
module scg_gate_decode
(
  input  wire logic                 sleepActive,
  input  wire scg_pkg::scg_word_t   sleepGate,
  input  wire scg_pkg::scg_units_t  runEnable,
  input  wire scg_pkg::scg_units_t  unitAccess,
  output logic      [`SCG_NUM_UNITS-1:0] unitClkEn,
  output logic                      unitBusFault
);
  import scg_pkg::*;

  scg_units_t sleepVec;

  // ****************************************
  // gather register bits per unit
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `SCG_NUM_PORTS; i++)
    begin : g_port
      assign sleepVec[i] = sleepGate[`SCG_BIT_PORT_LO + i];
    end
  endgenerate
  assign sleepVec[`SCG_UNIT_MICRO_DMA_GATE] = sleepGate[`SCG_BIT_MICRO_DMA_GATE];
  assign sleepVec[`SCG_UNIT_USB]  = sleepGate[`SCG_BIT_USB];

  // ****************************************
  // mode select: sleep value only in sleep
  // ****************************************
  assign unitClkEn    = sleepActive ? sleepVec : runEnable;
  assign unitBusFault = |(unitAccess & ~unitClkEn);
endmodule // scg_gate_decode

/* logic/scg_pkg.sv */
package scg_pkg;
  `include "scg_defines.svh"

  typedef logic [31:0]                   scg_word_t;
  typedef logic [`SCG_ADDR_W-1:0]        scg_addr_t;
  typedef logic [`SCG_NUM_UNITS-1:0]     scg_units_t;

  typedef enum logic [1:0]
  {
    SCG_IDLE   = 2'b01,
    SCG_ACCESS = 2'b10
  } scg_state_e;

  typedef struct packed
  {
    scg_state_e state;
    scg_word_t  gate;
    scg_word_t  prdata;
    logic       pslverr;
    logic       sleepReq;
    logic       autoGate;
  } scg_state_s;
endpackage

/* logic/scg_sleep_gate.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "scg_defines.svh"

// Operation
// - each bit enables one unit's clock
// - access to unclocked unit gives bus fault
// - reset clears all gate bits
// - register applies during sleep only
// - sleep gating needs auto gating bit set
// - bit 16 usb, bit 13 dma
// - bits 7..0 gate ports h..a
// - reserved bits read zero, writes ignored
module scg_sleep_gate
(
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic                 clkEn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire scg_pkg::scg_addr_t   paddr,
  input  wire scg_pkg::scg_word_t   pwdata,
  output logic                      pready,
  output scg_pkg::scg_word_t        prdata,
  output logic                      pslverr,
  input  wire scg_pkg::scg_units_t  runEnable,
  input  wire scg_pkg::scg_units_t  unitAccess,
  output scg_pkg::scg_units_t       unitClkEn,
  output logic                      unitBusFault,
  output logic                      sleepActive
);
  import scg_pkg::*;

  scg_state_s cur_r;
  scg_state_s cur_nxt;
  logic       hitGate;
  logic       hitMode;

  // ****************************************
  // apb decode
  // ****************************************
  assign hitGate = (paddr == `SCG_OFF_SLEEP_GATE);
  assign hitMode = (paddr == `SCG_OFF_MODE_CTRL);
  // one wait state keeps read data registered
  assign pready  = (cur_r.state == SCG_ACCESS);
  assign prdata  = cur_r.prdata;
  assign pslverr = cur_r.pslverr;
  // sleep gating only with automatic gating on
  assign sleepActive = cur_r.sleepReq & cur_r.autoGate;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    cur_nxt = cur_r;
    case (cur_r.state)
      SCG_IDLE:
      begin
        if (psel && penable)
        begin
          cur_nxt.state   = SCG_ACCESS;
          cur_nxt.pslverr = !(hitGate || hitMode);
          cur_nxt.prdata  = `SCG_ZERO_WORD;
          if (hitGate && !pwrite)
          begin
            cur_nxt.prdata = cur_r.gate & `SCG_GATE_MASK;
          end
          if (hitMode && !pwrite)
          begin
            cur_nxt.prdata[`SCG_BIT_SLEEP] = cur_r.sleepReq;
            cur_nxt.prdata[`SCG_BIT_ACG]   = cur_r.autoGate;
          end
          if (hitGate && pwrite)
          begin
            cur_nxt.gate = pwdata & `SCG_GATE_MASK;
          end
          if (hitMode && pwrite)
          begin
            cur_nxt.sleepReq = pwdata[`SCG_BIT_SLEEP];
            cur_nxt.autoGate = pwdata[`SCG_BIT_ACG];
          end
        end
      end
      SCG_ACCESS:
      begin
        cur_nxt.state = SCG_IDLE;
      end
      default:
      begin
        cur_nxt.state = SCG_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      cur_r.state    <= SCG_IDLE;
      cur_r.gate     <= `SCG_GATE_RESET;
      cur_r.prdata   <= `SCG_ZERO_WORD;
      cur_r.pslverr  <= 1'b0;
      cur_r.sleepReq <= 1'b0;
      cur_r.autoGate <= 1'b0;
    end
    else if (clkEn)
    begin
      cur_r <= cur_nxt;
    end
  end

  // ****************************************
  // unit gating
  // ****************************************
  scg_gate_decode u_decode
  (
    .sleepActive  (sleepActive),
    .sleepGate    (cur_r.gate),
    .runEnable    (runEnable),
    .unitAccess   (unitAccess),
    .unitClkEn    (unitClkEn),
    .unitBusFault (unitBusFault)
  );
endmodule // scg_sleep_gate
